// >>> design/tmb_timer_end.sv
// Purpose: 16-bit counter with shared high-byte staging for byte-wide access
// Assumes: tick_in is a one-cycle enable from an external prescaler or edge detector
// Notes:   compare, capture event and waveform pins live elsewhere
module tmb_timer_end #(
  parameter int CNT_W = tmb_pkg::CNT_W
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  tmb_bus_if.timer              bus,
  input  wire logic             tick_in,
  input  wire logic             capture_stb,
  output logic [CNT_W-1:0]      count_value,
  output logic [CNT_W-1:0]      match_reg_a,
  output logic [CNT_W-1:0]      match_reg_b,
  output logic [CNT_W-1:0]      capture_reg,
  output logic                  timer_tick,
  output logic                  count_top,
  output logic                  count_floor,
  output logic                  overflow_flag
);
  logic [7:0]       stage_hi;
  logic [7:0]       timer_ctrl_a;
  logic [7:0]       timer_ctrl_b;
  logic             count_down;
  logic [3:0]       wave_mode_sel;
  logic [2:0]       clock_source_sel;
  logic [15:0]      ceiling;
  tmb_pkg::tmb_seq_t seq;
  logic             tick;
  logic             at_top;
  logic             at_floor;
  logic             lo_wr;
  logic [7:0]       next_rdata;

  assign wave_mode_sel    = {timer_ctrl_b[tmb_pkg::CTRL_B_WGM_LSB +: 2],
                             timer_ctrl_a[tmb_pkg::CTRL_A_WGM_LSB +: 2]};
  assign clock_source_sel = timer_ctrl_b[tmb_pkg::CTRL_B_CS_LSB +: 3];
  assign tick     = tick_in && (clock_source_sel != tmb_pkg::CS_STOPPED);
  assign at_top   = (count_value == ceiling);
  assign at_floor = (count_value == tmb_pkg::CNT_FLOOR);

  always_comb begin
    seq     = tmb_pkg::TMB_SEQ_UP;
    ceiling = tmb_pkg::CNT_MAX;
    case (wave_mode_sel)
      4'h1, 4'h5: ceiling = tmb_pkg::TOP_8BIT;
      4'h2, 4'h6: ceiling = tmb_pkg::TOP_9BIT;
      4'h3, 4'h7: ceiling = tmb_pkg::TOP_10BIT;
      4'h4, 4'hF: ceiling = match_reg_a;
      4'hC, 4'hE: ceiling = capture_reg;
      4'h8, 4'hA: ceiling = capture_reg;
      4'h9, 4'hB: ceiling = match_reg_a;
      default:    ceiling = tmb_pkg::CNT_MAX;
    endcase
    case (wave_mode_sel)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: seq = tmb_pkg::TMB_SEQ_UPDOWN;
      4'h4, 4'hC:                               seq = tmb_pkg::TMB_SEQ_CLEAR;
      default:                                  seq = tmb_pkg::TMB_SEQ_UP;
    endcase
  end

  assign lo_wr = bus.wr_stb && (bus.sel == tmb_pkg::TMB_CNT_LO);

  // single staging byte for all wide registers
  // only high writes and counter or capture low reads load it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage_hi <= tmb_pkg::STAGE_RESET;
    end else if (bus.wr_stb) begin
      case (bus.sel)
        // every high write (counter, match A, match B, capture) goes to staging
        tmb_pkg::TMB_CNT_HI, tmb_pkg::TMB_MA_HI,
        tmb_pkg::TMB_MB_HI, tmb_pkg::TMB_CAP_HI: stage_hi <= bus.wdata;
        default: stage_hi <= stage_hi;
      endcase
    end else if (bus.rd_stb) begin
      case (bus.sel)
        tmb_pkg::TMB_CNT_LO: stage_hi <= count_value[15:8];
        tmb_pkg::TMB_CAP_LO: stage_hi <= capture_reg[15:8];
        default: stage_hi <= stage_hi;
      endcase
    end
  end

  // whole word loads on low write
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      match_reg_a  <= tmb_pkg::CNT_RESET;
      match_reg_b  <= tmb_pkg::CNT_RESET;
      timer_ctrl_a <= tmb_pkg::CTRL_RESET;
      timer_ctrl_b <= tmb_pkg::CTRL_RESET;
    end else if (bus.wr_stb) begin
      case (bus.sel)
        tmb_pkg::TMB_MA_LO:  match_reg_a  <= {stage_hi, bus.wdata};
        tmb_pkg::TMB_MB_LO:  match_reg_b  <= {stage_hi, bus.wdata};
        tmb_pkg::TMB_CTRL_A: timer_ctrl_a <= bus.wdata;
        tmb_pkg::TMB_CTRL_B: timer_ctrl_b <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Capture takes the counter; a processor write in the same cycle wins
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      capture_reg <= tmb_pkg::CNT_RESET;
    end else if (bus.wr_stb && bus.sel == tmb_pkg::TMB_CAP_LO) begin
      capture_reg <= {stage_hi, bus.wdata};
    end else if (capture_stb) begin
      capture_reg <= count_value;
    end
  end

  // clear, up or down per tick
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_value <= tmb_pkg::CNT_RESET;
      count_down  <= 1'b0;
    end else if (lo_wr) begin
      count_value <= {stage_hi, bus.wdata};
    end else if (tick) begin
      case (seq)
        tmb_pkg::TMB_SEQ_CLEAR: begin
          count_value <= at_top ? tmb_pkg::CNT_FLOOR : count_value + 16'h0001;
          count_down  <= 1'b0;
        end
        tmb_pkg::TMB_SEQ_UPDOWN: begin
          if (at_top) begin
            count_down  <= 1'b1;
            count_value <= count_value - 16'h0001;
          end else if (count_down && at_floor) begin
            count_down  <= 1'b0;
            count_value <= count_value + 16'h0001;
          end else if (count_down) begin
            count_value <= count_value - 16'h0001;
          end else begin
            count_value <= count_value + 16'h0001;
          end
        end
        default: begin
          count_value <= at_top ? tmb_pkg::CNT_FLOOR : count_value + 16'h0001;
          count_down  <= 1'b0;
        end
      endcase
    end
  end

  // overflow at floor for dual slope, at ceiling otherwise
  // Software clears by writing one; a same-cycle set wins
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_flag <= 1'b0;
    end else if (tick && !lo_wr &&
                 ((seq == tmb_pkg::TMB_SEQ_UPDOWN) ? (count_down && at_floor) : at_top)) begin
      overflow_flag <= 1'b1;
    end else if (bus.wr_stb && bus.sel == tmb_pkg::TMB_STATUS &&
                 bus.wdata[tmb_pkg::STATUS_OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_top   <= 1'b0;
      count_floor <= 1'b0;
      timer_tick  <= 1'b0;
    end else begin
      count_top   <= at_top;
      count_floor <= at_floor;
      timer_tick  <= tick;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (bus.sel)
      tmb_pkg::TMB_CNT_LO:  next_rdata = count_value[7:0];
      tmb_pkg::TMB_CNT_HI:  next_rdata = stage_hi;
      tmb_pkg::TMB_MA_LO:   next_rdata = match_reg_a[7:0];
      tmb_pkg::TMB_MA_HI:   next_rdata = match_reg_a[15:8];
      tmb_pkg::TMB_MB_LO:   next_rdata = match_reg_b[7:0];
      tmb_pkg::TMB_MB_HI:   next_rdata = match_reg_b[15:8];
      tmb_pkg::TMB_CAP_LO:  next_rdata = capture_reg[7:0];
      tmb_pkg::TMB_CAP_HI:  next_rdata = stage_hi;
      tmb_pkg::TMB_CTRL_A:  next_rdata = timer_ctrl_a;
      tmb_pkg::TMB_CTRL_B:  next_rdata = timer_ctrl_b;
      tmb_pkg::TMB_STATUS:  next_rdata = {7'h00, overflow_flag};
      default:              next_rdata = 8'h00;
    endcase
  end
  // Combinational so the low byte is seen in the strobe cycle, as the bus expects
  assign bus.rdata = next_rdata;
endmodule // tmb_timer_end

// >>> design/tmb_pkg.sv
// Purpose: shared constants and types for the 16-bit timer and its byte-wide access path
// Assumes: one system clock; 8-bit processor bus with one-cycle strobes
// Notes:   register selects are local codes of the byte-access port
package tmb_pkg;

  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;

  // Byte locations on the access port
  typedef enum logic [3:0] {
    TMB_CNT_LO  = 4'h0,
    TMB_CNT_HI  = 4'h1,
    TMB_MA_LO   = 4'h2,
    TMB_MA_HI   = 4'h3,
    TMB_MB_LO   = 4'h4,
    TMB_MB_HI   = 4'h5,
    TMB_CAP_LO  = 4'h6,
    TMB_CAP_HI  = 4'h7,
    TMB_CTRL_A  = 4'h8,
    TMB_CTRL_B  = 4'h9,
    TMB_STATUS  = 4'hA
  } tmb_sel_t;

  // Field positions
  localparam int CTRL_A_WGM_LSB = 0;   // Mode bits 1:0 in control A
  localparam int CTRL_B_CS_LSB  = 0;   // Clock source in control B bits 2:0
  localparam int CTRL_B_WGM_LSB = 3;   // Mode bits 3:2 in control B bits 4:3
  localparam int STATUS_OVF_BIT = 0;

  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  STAGE_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET   = 16'h0000;

  localparam logic [15:0] CNT_FLOOR = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  localparam logic [2:0] CS_STOPPED = 3'h0;

  typedef enum logic [1:0] {
    TMB_TOP_FIXED_MAX,
    TMB_TOP_FIXED,
    TMB_TOP_MATCH_A,
    TMB_TOP_CAPTURE
  } tmb_top_src_t;

  typedef enum logic [1:0] {
    TMB_SEQ_UP,      // Count up, wrap at ceiling
    TMB_SEQ_CLEAR,   // Count up, clear at ceiling
    TMB_SEQ_UPDOWN   // Count up to ceiling, then down to floor
  } tmb_seq_t;

endpackage : tmb_pkg

// >>> design/tmb_bus_if.sv
// Purpose: byte-wide register access between processor end and timer end
// Assumes: wr_stb and rd_stb are single-cycle, never both high together
// Notes:   read data is combinational in the strobe cycle
interface tmb_bus_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [3:0] sel;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport timer (
    input  wr_stb,
    input  rd_stb,
    input  sel,
    input  wdata,
    output rdata
  );

  modport cpu (
    output wr_stb,
    output rd_stb,
    output sel,
    output wdata,
    input  rdata
  );
endinterface : tmb_bus_if

// >>> design/tmb_cpu_end.sv
// Purpose: processor-side master that moves 16-bit values as two ordered byte accesses
// Assumes: user requests are held until req_done; one request at a time
// Notes:   a block runs start to finish, so no other access splits a pair
module tmb_cpu_end (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  tmb_bus_if.cpu           bus,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_wide,
  input  wire logic [3:0]  req_sel,
  input  wire logic [15:0] req_wdata,
  output logic             req_done,
  output logic [15:0]      req_rdata
);
  typedef enum logic [1:0] {TMB_C_IDLE, TMB_C_FIRST, TMB_C_SECOND} tmb_cst_t;
  tmb_cst_t   state;
  logic [7:0] lo_keep;

  // high write first, low read first
  // pair never split by another access
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= TMB_C_IDLE;
      bus.wr_stb    <= 1'b0;
      bus.rd_stb    <= 1'b0;
      bus.sel       <= 4'h0;
      bus.wdata     <= 8'h00;
      req_done      <= 1'b0;
      req_rdata     <= 16'h0000;
      lo_keep       <= 8'h00;
    end else begin
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      req_done   <= 1'b0;
      case (state)
        TMB_C_IDLE: begin
          if (req_valid && !req_done) begin
            bus.wr_stb <= req_write;
            bus.rd_stb <= !req_write;
            if (!req_wide) begin
              bus.sel   <= req_sel;
              bus.wdata <= req_wdata[7:0];
              state     <= TMB_C_SECOND;
            end else if (req_write) begin
              bus.sel   <= req_sel | 4'h1;
              bus.wdata <= req_wdata[15:8];
              state     <= TMB_C_FIRST;
            end else begin
              bus.sel   <= req_sel & 4'hE;
              state     <= TMB_C_FIRST;
            end
          end
        end
        TMB_C_FIRST: begin
          lo_keep    <= bus.rdata;
          bus.wr_stb <= req_write;
          bus.rd_stb <= !req_write;
          if (req_write) begin
            bus.sel   <= req_sel & 4'hE;
            bus.wdata <= req_wdata[7:0];
          end else begin
            bus.sel   <= req_sel | 4'h1;
          end
          state <= TMB_C_SECOND;
        end
        TMB_C_SECOND: begin
          req_done <= 1'b1;
          if (req_wide) begin
            req_rdata <= {bus.rdata, lo_keep};
          end else begin
            req_rdata <= {8'h00, bus.rdata};
          end
          state <= TMB_C_IDLE;
        end
        default: state <= TMB_C_IDLE;
      endcase
    end
  end
endmodule // tmb_cpu_end

// >>> verification/tmb_assertions.sv
// Purpose: bus-side checks of byte access to the 16-bit timer
// Assumes: high-byte writes and low-byte reads only come as pairs
// Notes:   staging, match and control values are tracked from bus traffic
module tmb_assertions (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [3:0] sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  stg;
  logic [7:0]  ctl_a;
  logic [7:0]  ctl_b;
  logic        stg_ok;
  logic        cnt_ok;
  logic [15:0] cnt;
  logic [15:0] ma;
  logic [15:0] mb;
  wire         hi_wr = wr_stb && sel[0] && !sel[3];
  wire         lo_wr = wr_stb && !sel[0] && !sel[3];

  // Staging model; a capture read leaves it unknown to the bus
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stg    <= tmb_pkg::STAGE_RESET;
      stg_ok <= 1'b1;
    end else if (hi_wr) begin
      stg    <= wdata;
      stg_ok <= 1'b1;
    end else if (rd_stb && sel == tmb_pkg::TMB_CNT_LO) begin
      stg    <= cnt[15:8];
      stg_ok <= cnt_ok;
    end else if (rd_stb && sel == tmb_pkg::TMB_CAP_LO) begin
      stg_ok <= 1'b0;
    end
  end

  // Counter is only known while stopped since its last write
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt    <= tmb_pkg::CNT_RESET;
      cnt_ok <= 1'b1;
    end else if (lo_wr && sel == tmb_pkg::TMB_CNT_LO) begin
      cnt    <= {stg, wdata};
      cnt_ok <= stg_ok && ctl_b[2:0] == tmb_pkg::CS_STOPPED;
    end else if (ctl_b[2:0] != tmb_pkg::CS_STOPPED) begin
      cnt_ok <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ma <= tmb_pkg::CNT_RESET;
      mb <= tmb_pkg::CNT_RESET;
    end else if (lo_wr && sel == tmb_pkg::TMB_MA_LO) begin
      ma <= {stg, wdata};
    end else if (lo_wr && sel == tmb_pkg::TMB_MB_LO) begin
      mb <= {stg, wdata};
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_a <= tmb_pkg::CTRL_RESET;
      ctl_b <= tmb_pkg::CTRL_RESET;
    end else if (wr_stb && sel == tmb_pkg::TMB_CTRL_A) begin
      ctl_a <= wdata;
    end else if (wr_stb && sel == tmb_pkg::TMB_CTRL_B) begin
      ctl_b <= wdata;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_hi_wr;
    hi_wr;
  endsequence
  sequence s_lo_wr_next;
    wr_stb && sel == {$past(sel[3:1]), 1'b0};
  endsequence
  sequence s_pair;
    (wr_stb || rd_stb) [*2];
  endsequence

  property p_write_order;
    s_hi_wr |=> s_lo_wr_next;
  endproperty
  property p_read_order;
    rd_stb && !sel[0] && !sel[3] |=> rd_stb && sel == {$past(sel[3:1]), 1'b1};
  endproperty
  property p_pair_gap;
    s_pair |=> !(wr_stb || rd_stb);
  endproperty
  property p_stage_read;
    rd_stb && stg_ok && (sel == tmb_pkg::TMB_CNT_HI || sel == tmb_pkg::TMB_CAP_HI)
      |-> rdata == stg;
  endproperty
  property p_match_hi;
    rd_stb && (sel == tmb_pkg::TMB_MA_HI || sel == tmb_pkg::TMB_MB_HI)
      |-> rdata == (sel == tmb_pkg::TMB_MA_HI ? ma[15:8] : mb[15:8]);
  endproperty
  property p_match_lo;
    rd_stb && (sel == tmb_pkg::TMB_MA_LO || sel == tmb_pkg::TMB_MB_LO)
      |-> rdata == (sel == tmb_pkg::TMB_MA_LO ? ma[7:0] : mb[7:0]);
  endproperty
  property p_cnt_lo;
    rd_stb && cnt_ok && sel == tmb_pkg::TMB_CNT_LO |-> rdata == cnt[7:0];
  endproperty
  property p_ctrl_read;
    rd_stb && (sel == tmb_pkg::TMB_CTRL_A || sel == tmb_pkg::TMB_CTRL_B)
      |-> (sel == tmb_pkg::TMB_CTRL_A ? rdata[1:0] == ctl_a[1:0] : rdata[4:0] == ctl_b[4:0]);
  endproperty

  a_write_order: assert property (p_write_order)
    else $error("high write not followed by its low write");
  a_read_order: assert property (p_read_order)
    else $error("low read not followed by its high read");
  a_pair_gap: assert property (p_pair_gap)
    else $error("access splits or extends a byte pair");
  a_stage_read: assert property (p_stage_read)
    else $error("high location read did not return staged byte");
  a_match_hi: assert property (p_match_hi)
    else $error("match high read not direct");
  a_match_lo: assert property (p_match_lo)
    else $error("match low byte wrong");
  a_cnt_lo: assert property (p_cnt_lo)
    else $error("stopped counter low byte wrong");
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("mode or clock select field lost");
endmodule // tmb_assertions

// >>> verification/timer16_counter_byte_access_tb.sv
// Purpose: drives the processor end and judges the timer end
// Assumes: only pairs write high bytes and read low bytes; single high reads also occur
// Notes:   waveform outputs are outside this bench
`define CHK(got, want) begin \
  checks_done++; \
  if ((got) !== (want)) begin \
    failures++; \
    $display("BAD %0t got %h want %h", $time, got, want); \
  end \
end
module timer16_counter_byte_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        req_wide = 1'b0;
  logic [3:0]  req_sel = 4'h0;
  logic [15:0] req_wdata = 16'h0000;
  logic        tick_in = 1'b0;
  logic        capture_stb = 1'b0;
  logic        req_done, timer_tick, count_top, count_floor, overflow_flag;
  logic [15:0] req_rdata, count_value, match_reg_a, match_reg_b, capture_reg, rd;
  int          failures = 0;
  int          checks_done = 0;

  tmb_bus_if tmb_bus_if_i ();
  tmb_cpu_end tmb_cpu_end_i (.clock(clock), .sys_rst(sys_rst), .bus(tmb_bus_if_i),
    .req_valid(req_valid), .req_write(req_write), .req_wide(req_wide), .req_sel(req_sel),
    .req_wdata(req_wdata), .req_done(req_done), .req_rdata(req_rdata));
  tmb_timer_end tmb_timer_end_i (.clock(clock), .sys_rst(sys_rst), .bus(tmb_bus_if_i),
    .tick_in(tick_in), .capture_stb(capture_stb), .count_value(count_value),
    .match_reg_a(match_reg_a), .match_reg_b(match_reg_b), .capture_reg(capture_reg),
    .timer_tick(timer_tick), .count_top(count_top), .count_floor(count_floor),
    .overflow_flag(overflow_flag));
  tmb_assertions tmb_assertions_i (.clock(clock), .sys_rst(sys_rst),
    .wr_stb(tmb_bus_if_i.wr_stb), .rd_stb(tmb_bus_if_i.rd_stb), .sel(tmb_bus_if_i.sel),
    .wdata(tmb_bus_if_i.wdata), .rdata(tmb_bus_if_i.rdata));

  always #5 clock = ~clock;

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Request held until the done pulse, then released
  task automatic acc(input logic wr, input logic wide, input logic [3:0] s,
                     input logic [15:0] wd);
    int n;
    @(posedge clock);
    #1;
    req_valid = 1'b1;
    req_write = wr;
    req_wide = wide;
    req_sel = s;
    req_wdata = wd;
    n = 0;
    while (req_done !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    rd = req_rdata;
    req_valid = 1'b0;
    if (n >= 20) begin
      failures++;
      end_of_test();
    end
  endtask

  // Spaced ticks leave room for the registered tick path
  task automatic ticks(input int k);
    repeat (k) begin
      tick_in = 1'b1;
      @(posedge clock);
      #1;
      tick_in = 1'b0;
      repeat (3) @(posedge clock);
      #1;
    end
  endtask

  task automatic t_reset();
    `CHK(count_value, tmb_pkg::CNT_RESET);
    `CHK(overflow_flag, 1'b0);
    `CHK(count_floor, 1'b1);
    acc(1'b0, 1'b1, tmb_pkg::TMB_CNT_LO, 16'h0000);
    `CHK(rd, tmb_pkg::CNT_FLOOR);
  endtask

  task automatic t_pair();
    acc(1'b1, 1'b1, tmb_pkg::TMB_CNT_LO, 16'h01FF);
    `CHK(count_value, 16'h01FF);
    acc(1'b0, 1'b1, tmb_pkg::TMB_CNT_LO, 16'h0000);
    `CHK(rd, 16'h01FF);
    acc(1'b0, 1'b0, tmb_pkg::TMB_CNT_HI, 16'h0000);
    `CHK(rd[7:0], 8'h01);
  endtask

  task automatic t_share();
    acc(1'b1, 1'b1, tmb_pkg::TMB_MA_LO, 16'hA55A);
    acc(1'b1, 1'b0, tmb_pkg::TMB_MB_LO, 16'h003C);
    `CHK(match_reg_b, 16'hA53C);
    acc(1'b0, 1'b1, tmb_pkg::TMB_CNT_LO, 16'h0000);
    acc(1'b0, 1'b0, tmb_pkg::TMB_MA_HI, 16'h0000);
    `CHK(rd[7:0], 8'hA5);
    acc(1'b0, 1'b0, tmb_pkg::TMB_CNT_HI, 16'h0000);
    `CHK(rd[7:0], 8'h01);
    acc(1'b0, 1'b1, tmb_pkg::TMB_MB_LO, 16'h0000);
    `CHK(rd, 16'hA53C);
    `CHK(match_reg_a, 16'hA55A);
  endtask

  task automatic t_modes();
    ticks(2);
    `CHK(count_value, 16'h01FF);
    capture_stb = 1'b1;
    @(posedge clock);
    #1;
    capture_stb = 1'b0;
    acc(1'b0, 1'b1, tmb_pkg::TMB_CAP_LO, 16'h0000);
    `CHK(rd, 16'h01FF);
    acc(1'b1, 1'b1, tmb_pkg::TMB_CNT_LO, 16'hFFFE);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0001);
    ticks(1);
    `CHK(count_value, tmb_pkg::CNT_MAX);
    `CHK(count_top, 1'b1);
    ticks(1);
    `CHK(count_value, tmb_pkg::CNT_FLOOR);
    `CHK(overflow_flag, 1'b1);
    acc(1'b0, 1'b0, tmb_pkg::TMB_STATUS, 16'h0000);
    `CHK(rd[0], 1'b1);
    acc(1'b1, 1'b0, tmb_pkg::TMB_STATUS, 16'h0001);
    `CHK(overflow_flag, 1'b0);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0000);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_A, 16'h0001);
    acc(1'b1, 1'b1, tmb_pkg::TMB_CNT_LO, 16'h00FE);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0001);
    ticks(1);
    `CHK(count_value, tmb_pkg::TOP_8BIT);
    `CHK(count_top, 1'b1);
    ticks(1);
    `CHK(count_value, 16'h00FE);
    acc(1'b0, 1'b0, tmb_pkg::TMB_CTRL_A, 16'h0000);
    `CHK(rd[1:0], 2'b01);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0000);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_A, 16'h0000);
    acc(1'b1, 1'b1, tmb_pkg::TMB_MA_LO, 16'h0005);
    acc(1'b1, 1'b1, tmb_pkg::TMB_CNT_LO, 16'h0004);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0009);
    ticks(2);
    `CHK(count_value, tmb_pkg::CNT_FLOOR);
    acc(1'b0, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0000);
    `CHK(rd[4:0], 5'h09);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0000);
    // Capture as ceiling, clear at top
    acc(1'b1, 1'b1, tmb_pkg::TMB_CAP_LO, 16'h0003);
    acc(1'b1, 1'b1, tmb_pkg::TMB_CNT_LO, 16'h0002);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0019);
    ticks(1);
    `CHK(count_value, 16'h0003);
    `CHK(count_top, 1'b1);
    ticks(1);
    `CHK(count_value, tmb_pkg::CNT_FLOOR);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0000);
  endtask

  // Write lands while ticks arrive every cycle
  task automatic t_priority();
    int n;
    tick_in = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    `CHK(timer_tick, 1'b0);
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0001);
    fork
      acc(1'b1, 1'b1, tmb_pkg::TMB_CNT_LO, 16'h1234);
      begin
        n = 0;
        while (!(tmb_bus_if_i.wr_stb === 1'b1 && tmb_bus_if_i.sel === 4'h0) && n < 20) begin
          @(posedge clock);
          #1;
          n++;
        end
        if (n >= 20) begin
          failures++;
          end_of_test();
        end
        @(posedge clock);
        #1;
        `CHK(count_value, 16'h1234);
        @(posedge clock);
        #1;
        `CHK(count_value, 16'h1235);
        `CHK(timer_tick, 1'b1);
      end
    join
    tick_in = 1'b0;
    acc(1'b1, 1'b0, tmb_pkg::TMB_CTRL_B, 16'h0000);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    t_reset();
    t_pair();
    t_share();
    t_modes();
    t_priority();
    end_of_test();
  end
endmodule // timer16_counter_byte_access_tb
